// ### src/burst_and_gate_controller.sv
// Burst and gate controller for the main waveform with Avalon-MM registers
//
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module burst_and_gate_controller
(
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   input  wire logic [bg_pkg::ADDR_W-1:0] i_avs_address,
   input  wire logic                      i_avs_read,
   input  wire logic                      i_avs_write,
   input  wire logic [31:0]               i_avs_writedata,
   input  wire logic [3:0]                i_avs_byteenable,
   output var  logic [31:0]               o_avs_readdata,
   output var  logic                      o_avs_waitrequest,
   input  wire logic                      i_external_trigger_input,
   input  wire logic                      i_manual_sync_key,
   input  wire logic                      i_burst_mode_key,
   input  wire logic                      i_gate_key,
   input  wire logic                      i_aux_square,
   output var  logic                      o_main_run,
   output var  logic                      o_trigger_sweep_output,
   output var  logic                      o_burst_active,
   output var  logic                      o_phase_adjust_en
);
   import bg_pkg::*;

   localparam int unsigned NSYNC = 5;
   localparam int unsigned P_EXT = 0;
   localparam int unsigned P_SYNC = 1;
   localparam int unsigned P_BKEY = 2;
   localparam int unsigned P_GKEY = 3;
   localparam int unsigned P_AUX = 4;

   logic [CTL_W-1:0]  ctrl_q;
   logic [CNT_W-1:0]  count_q;
   logic [CNT_W-1:0]  remain_q;
   logic [STEP_W-1:0] steps_q;
   logic [31:0]       period_q;
   logic [2:0]        sync_q [NSYNC];
   logic [NSYNC-1:0]  level_q;
   logic [NSYNC-1:0]  rise_d;
   logic [NSYNC-1:0]  fall_d;
   logic              internal_trigger_generator_sq;
   logic              internal_trigger_generator_q;
   logic              internal_trigger_generator_rise_d;
   logic              burst_en_q;
   logic              gate_en_q;
   logic              man_gate_q;
   logic              wr_d;
   logic              rd_d;
   logic              key_burst_d;
   logic              key_gate_d;
   logic              man_ev_d;
   logic              burst_mode_key_d;
   logic              gate_cond_d;
   logic              edge_d;
   logic              half_mode;
   logic [31:0]       status_d;
   src_t              bsrc;
   src_t              gsrc;
   burst_state_t      state_q;

   assign bsrc      = src_t'(ctrl_q[CTL_BSRC_LO +: 2]);
   assign gsrc      = src_t'(ctrl_q[CTL_GSRC_LO +: 2]);
   assign half_mode = ctrl_q[CTL_HALF];

   // Bus strobes: a request is taken on the edge where waitrequest is low
   assign wr_d = i_avs_write && !o_avs_waitrequest;
   assign rd_d = i_avs_read && !o_avs_waitrequest;

   // Pin synchronisers, three stages; a level counts when stages two and three agree
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < NSYNC; i++)
            sync_q[i] <= 3'h0;
         level_q <= '0;
      end
      else
      begin
         for (int i = 0; i < NSYNC; i++)
         begin
            sync_q[i] <= {sync_q[i][1:0], 1'b0};
            if (sync_q[i][1] == sync_q[i][2])
               level_q[i] <= sync_q[i][2];
         end
         sync_q[P_EXT][0]  <= i_external_trigger_input;
         sync_q[P_SYNC][0] <= i_manual_sync_key;
         sync_q[P_BKEY][0] <= i_burst_mode_key;
         sync_q[P_GKEY][0] <= i_gate_key;
         sync_q[P_AUX][0]  <= i_aux_square;
      end
   end

   always_comb
   begin
      for (int i = 0; i < NSYNC; i++)
      begin
         rise_d[i] = (sync_q[i][1] == sync_q[i][2]) && sync_q[i][2] && !level_q[i];
         fall_d[i] = (sync_q[i][1] == sync_q[i][2]) && !sync_q[i][2] && level_q[i];
      end
   end

   // Key presses from the panel or from a remote write
   assign key_burst_d = rise_d[P_BKEY] || (wr_d && i_avs_address == OFS_KEYS
                        && i_avs_byteenable[0] && i_avs_writedata[KEY_BURST]);
   assign key_gate_d  = rise_d[P_GKEY] || (wr_d && i_avs_address == OFS_KEYS
                        && i_avs_byteenable[0] && i_avs_writedata[KEY_GATE]);
   assign man_ev_d    = rise_d[P_SYNC] || (wr_d && i_avs_address == OFS_KEYS
                        && i_avs_byteenable[0] && i_avs_writedata[KEY_SYNC]);

   // Register writes
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         ctrl_q   <= '0;
         count_q  <= CNT_RESET;
         period_q <= PERIOD_RESET_US;
      end
      else if (wr_d)
      begin
         case (i_avs_address)
            OFS_CTRL:
            begin
               if (i_avs_byteenable[0])
                  ctrl_q[7:2] <= i_avs_writedata[7:2];
               if (i_avs_byteenable[1])
                  ctrl_q[CTL_W-1:8] <= i_avs_writedata[CTL_W-1:8];
            end
            OFS_COUNT:
            begin
               if (i_avs_byteenable[0])
                  count_q[7:0] <= i_avs_writedata[7:0];
               if (i_avs_byteenable[1])
                  count_q[CNT_W-1:8] <= i_avs_writedata[CNT_W-1:8];
            end
            OFS_PERIOD:
            begin
               for (int b = 0; b < 4; b++)
                  if (i_avs_byteenable[b])
                     period_q[8*b +: 8] <= i_avs_writedata[8*b +: 8];
            end
            default:
               ;
         endcase
      end
   end

   // Rounded-up period in 10 us half-period steps
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         steps_q <= period_to_steps(PERIOD_RESET_US);
      else
         steps_q <= period_to_steps(period_q);
   end

   burst_mode_key_gen_divider u_internal_trigger_generator (
      .i_clk_sys (i_clk_sys),
      .i_rst     (i_rst),
      .i_steps   (steps_q),
      .o_square  (internal_trigger_generator_sq)
   );

   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         internal_trigger_generator_q <= 1'b0;
      else
         internal_trigger_generator_q <= internal_trigger_generator_sq;
   end

   assign internal_trigger_generator_rise_d = internal_trigger_generator_sq && !internal_trigger_generator_q;

   // Mode toggles; a software write of the enable bits also sets them
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         burst_en_q <= 1'b0;
         gate_en_q  <= 1'b0;
      end
      else
      begin
         if (key_burst_d)
            burst_en_q <= ~burst_en_q;
         else if (wr_d && i_avs_address == OFS_CTRL && i_avs_byteenable[0])
            burst_en_q <= i_avs_writedata[CTL_BURST_EN];
         if (key_gate_d)
            gate_en_q <= ~gate_en_q;
         else if (wr_d && i_avs_address == OFS_CTRL && i_avs_byteenable[0])
            gate_en_q <= i_avs_writedata[CTL_GATE_EN];
      end
   end

   // Manual gate state
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         man_gate_q <= 1'b0;
      else if (man_ev_d && gsrc == SRC_MANUAL)
         man_gate_q <= ~man_gate_q;
   end

   // Trigger selection
   always_comb
   begin
      case (bsrc)
         SRC_EXT:    burst_mode_key_d = rise_d[P_EXT];
         SRC_MANUAL: burst_mode_key_d = man_ev_d;
         SRC_INTERNAL_TRIGGER_GENERATOR:   burst_mode_key_d = internal_trigger_generator_rise_d;
         default:    burst_mode_key_d = 1'b0;
      endcase
   end

   // Gate condition
   always_comb
   begin
      case (gsrc)
         SRC_EXT:    gate_cond_d = level_q[P_EXT];
         SRC_MANUAL: gate_cond_d = man_gate_q;
         SRC_INTERNAL_TRIGGER_GENERATOR:   gate_cond_d = internal_trigger_generator_sq;
         default:    gate_cond_d = 1'b0;
      endcase
   end

   // Counted edges of the aux square: rises, plus falls in half-cycle mode
   assign edge_d = rise_d[P_AUX] || (half_mode && fall_d[P_AUX]);

   // Burst sequencer
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q  <= B_IDLE;
         remain_q <= '0;
      end
      else
      begin
         case (state_q)
            B_IDLE:
            begin
               if (burst_en_q && burst_mode_key_d && count_q != '0)
               begin
                  state_q  <= B_ARMED;
                  remain_q <= count_q;
               end
            end
            B_ARMED:
            begin
               if (!burst_en_q)
                  state_q <= B_IDLE;
               else if (rise_d[P_AUX])
                  state_q <= B_RUN;
            end
            B_RUN:
            begin
               if (!burst_en_q)
                  state_q <= B_IDLE;
               else if (edge_d)
               begin
                  if (remain_q == CNT_W'(1))
                     state_q <= B_IDLE;
                  remain_q <= remain_q - CNT_W'(1);
               end
            end
            default:
               state_q <= B_IDLE;
         endcase
      end
   end

   // Outputs
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_main_run             <= 1'b1;
         o_burst_active         <= 1'b0;
         o_trigger_sweep_output <= 1'b0;
         o_phase_adjust_en      <= 1'b1;
      end
      else
      begin
         o_main_run <= (!burst_en_q && !gate_en_q)
                       || (burst_en_q && state_q == B_RUN)
                       || (gate_en_q && gate_cond_d);
         o_burst_active         <= state_q != B_IDLE;
         o_trigger_sweep_output <= internal_trigger_generator_sq;
         o_phase_adjust_en      <= !(ctrl_q[CTL_SINE_TRI] && ctrl_q[CTL_ABOVE_30K])
                                   || ctrl_q[CTL_LOW_FREQUENCY_AUX_MODE];
      end
   end

   // Status word
   always_comb
   begin
      status_d               = '0;
      status_d[ST_ARMED]     = state_q == B_ARMED;
      status_d[ST_RUN]       = state_q == B_RUN;
      status_d[ST_GATE_OPEN] = gate_en_q && gate_cond_d;
      status_d[ST_INTERNAL_TRIGGER_GENERATOR]      = internal_trigger_generator_sq;
      status_d[ST_USE_G]     = gsrc == SRC_INTERNAL_TRIGGER_GENERATOR;
      status_d[ST_USE_F]     = ctrl_q[CTL_FSK_INTERNAL_TRIGGER_GENERATOR];
      status_d[ST_USE_A]     = ctrl_q[CTL_AM_INTERNAL_TRIGGER_GENERATOR];
      status_d[ST_USE_T]     = bsrc == SRC_INTERNAL_TRIGGER_GENERATOR;
      status_d[ST_FREE]      = !(gsrc == SRC_INTERNAL_TRIGGER_GENERATOR || ctrl_q[CTL_FSK_INTERNAL_TRIGGER_GENERATOR]
                                 || ctrl_q[CTL_AM_INTERNAL_TRIGGER_GENERATOR] || bsrc == SRC_INTERNAL_TRIGGER_GENERATOR);
      status_d[ST_MAN_GATE]  = man_gate_q;
      status_d[ST_PHASE_OK]  = o_phase_adjust_en;
   end

   // Avalon slave: one wait cycle, then waitrequest low for one cycle
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_avs_waitrequest <= 1'b1;
         o_avs_readdata    <= '0;
      end
      else if (o_avs_waitrequest && (i_avs_read || i_avs_write))
      begin
         o_avs_waitrequest <= 1'b0;
         case (i_avs_address)
            OFS_CTRL:
               o_avs_readdata <= {20'h0_0000, ctrl_q[CTL_W-1:2], gate_en_q, burst_en_q};
            OFS_COUNT:  o_avs_readdata <= {22'h00_0000, count_q};
            OFS_PERIOD: o_avs_readdata <= period_q;
            OFS_STATUS: o_avs_readdata <= status_d;
            default:    o_avs_readdata <= 32'h0000_0000;
         endcase
      end
      else
         o_avs_waitrequest <= 1'b1;
   end

   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);

   burst_ignore_a: assert property (
      state_q == B_RUN && !edge_d && burst_en_q |=> state_q == B_RUN)
      else $error("burst left run without an aux edge");

   burst_start_a: assert property (
      state_q == B_IDLE && burst_en_q && burst_mode_key_d && count_q != '0 |=> state_q == B_ARMED)
      else $error("trigger did not arm a burst");

   burst_aux_a: assert property (
      state_q == B_ARMED && burst_en_q && rise_d[P_AUX] |=> state_q == B_RUN)
      else $error("aux rise did not start burst");

   burst_end_a: assert property (
      state_q == B_RUN && burst_en_q && edge_d && remain_q == CNT_W'(1)
      |=> state_q == B_IDLE ##1 (!o_main_run || gate_en_q))
      else $error("burst did not stop on last edge");

   gate_level_a: assert property (
      gate_en_q && !burst_en_q && gate_cond_d |=> o_main_run)
      else $error("gate high but waveform off");

   gate_closed_a: assert property (
      gate_en_q && !burst_en_q && !gate_cond_d |=> !o_main_run)
      else $error("gate low but waveform on");

   tsweep_out_a: assert property (
      $rose(internal_trigger_generator_sq) |=> o_trigger_sweep_output)
      else $error("trigger sweep output not following generator");

   burst_key_a: assert property (
      key_burst_d |=> burst_en_q != $past(burst_en_q))
      else $error("burst key did not toggle");

   man_gate_a: assert property (
      man_ev_d && gsrc == SRC_MANUAL |=> man_gate_q != $past(man_gate_q))
      else $error("manual gate did not toggle");

   bus_answer_a: assert property (
      (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
      else $error("bus answer not one cycle after request");

   phase_gate_a: assert property (
      (ctrl_q[CTL_SINE_TRI] && ctrl_q[CTL_ABOVE_30K] && !ctrl_q[CTL_LOW_FREQUENCY_AUX_MODE]) [*2]
      |-> !o_phase_adjust_en)
      else $error("phase adjust allowed above 30 kHz");
endmodule
`default_nettype wire

// ### src/bg_pkg.sv
// Constants, register map and types for the burst and gate controller
package bg_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ          = 50_000_000;
   localparam int unsigned TICK_NS         = 10_000;
   localparam int unsigned TICK_CYCLES     = (TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int unsigned TICK_W          = 9;
   localparam int unsigned PERIOD_STEP_US  = 20;
   localparam int unsigned MIN_PERIOD_US   = 20;
   localparam int unsigned MAX_PERIOD_US   = 200_000_000;
   localparam int unsigned STEP_W          = 24;

   // Avalon-MM register map, byte addresses
   localparam int unsigned ADDR_W          = 5;
   localparam logic [4:0]  OFS_CTRL        = 5'h00;
   localparam logic [4:0]  OFS_COUNT       = 5'h04;
   localparam logic [4:0]  OFS_PERIOD      = 5'h08;
   localparam logic [4:0]  OFS_KEYS        = 5'h0c;
   localparam logic [4:0]  OFS_STATUS      = 5'h10;

   // Control fields
   localparam int unsigned CTL_BURST_EN    = 0;
   localparam int unsigned CTL_GATE_EN     = 1;
   localparam int unsigned CTL_BSRC_LO     = 2;
   localparam int unsigned CTL_GSRC_LO     = 4;
   localparam int unsigned CTL_HALF        = 6;
   localparam int unsigned CTL_LOW_FREQUENCY_AUX_MODE    = 7;
   localparam int unsigned CTL_FSK_INTERNAL_TRIGGER_GENERATOR    = 8;
   localparam int unsigned CTL_AM_INTERNAL_TRIGGER_GENERATOR     = 9;
   localparam int unsigned CTL_SINE_TRI    = 10;
   localparam int unsigned CTL_ABOVE_30K   = 11;
   localparam int unsigned CTL_W           = 12;

   // Key register fields, write-one pulses
   localparam int unsigned KEY_BURST       = 0;
   localparam int unsigned KEY_GATE        = 1;
   localparam int unsigned KEY_SYNC        = 2;

   // Status fields
   localparam int unsigned ST_ARMED        = 0;
   localparam int unsigned ST_RUN          = 1;
   localparam int unsigned ST_GATE_OPEN    = 2;
   localparam int unsigned ST_INTERNAL_TRIGGER_GENERATOR         = 3;
   localparam int unsigned ST_USE_G        = 4;
   localparam int unsigned ST_USE_F        = 5;
   localparam int unsigned ST_USE_A        = 6;
   localparam int unsigned ST_USE_T        = 7;
   localparam int unsigned ST_FREE         = 8;
   localparam int unsigned ST_MAN_GATE     = 9;
   localparam int unsigned ST_PHASE_OK     = 10;

   // Burst count, and the reset value of the period
   localparam int unsigned CNT_W           = 10;
   localparam logic [9:0]  CNT_RESET       = 10'h001;
   localparam logic [31:0] PERIOD_RESET_US = 32'h0000_03e8;

   typedef enum logic [1:0] {SRC_EXT, SRC_MANUAL, SRC_INTERNAL_TRIGGER_GENERATOR, SRC_SPARE} src_t;
   typedef enum logic [1:0] {B_IDLE, B_ARMED, B_RUN} burst_state_t;

   // Requested period in us, rounded up to the step and clamped to range
   function automatic logic [STEP_W-1:0] period_to_steps(input logic [31:0] us);
      logic [31:0] c;
      begin
         c = us;
         if (c < MIN_PERIOD_US)
            c = MIN_PERIOD_US;
         if (c > MAX_PERIOD_US)
            c = MAX_PERIOD_US;
         c = (c + (PERIOD_STEP_US - 1)) / PERIOD_STEP_US;
         period_to_steps = c[STEP_W-1:0];
      end
   endfunction
endpackage

// ### src/burst_mode_key_gen_divider.sv
// Internal trigger generator: divides the system clock into a 1:1 square wave
`timescale 1ns/1ps
`default_nettype none
module burst_mode_key_gen_divider
(
   input  wire logic                      i_clk_sys,
   input  wire logic                      i_rst,
   input  wire logic [bg_pkg::STEP_W-1:0] i_steps,
   output var  logic                      o_square
);
   import bg_pkg::*;

   logic [TICK_W-1:0] tick_q;
   logic [STEP_W-1:0] half_q;
   logic              tick_d;

   assign tick_d = (tick_q == TICK_W'(TICK_CYCLES - 1));

   // 10 us time base
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
         tick_q <= '0;
      else if (tick_d)
         tick_q <= '0;
      else
         tick_q <= tick_q + TICK_W'(1);
   end

   // Each half period lasts i_steps steps, 10 us each; high and low are equal
   always_ff @(posedge i_clk_sys or posedge i_rst)
   begin
      if (i_rst)
      begin
         half_q   <= '0;
         o_square <= 1'b0;
      end
      else if (tick_d)
      begin
         if (half_q >= i_steps - STEP_W'(1))
         begin
            half_q   <= '0;
            o_square <= ~o_square;
         end
         else
            half_q <= half_q + STEP_W'(1);
      end
   end
endmodule
`default_nettype wire

// ### tb/burst_mode_key_far_model.sv
// Far-side model: trigger source, operator keys and aux square
`timescale 1ns/1ps
`default_nettype none
module burst_mode_key_far_model
#(
   parameter int AUX_HALF = 20
)
(
   input  wire logic i_clk_sys,
   output var  logic o_ext,
   output var  logic o_sync,
   output var  logic o_bkey,
   output var  logic o_gkey,
   output var  logic o_aux
);
   int cnt = 0;
   initial {o_ext, o_sync, o_bkey, o_gkey, o_aux} = 5'h00;
   // Free-running aux square
   always @(posedge i_clk_sys)
   begin
      cnt <= (cnt == AUX_HALF - 1) ? 0 : cnt + 1;
      if (cnt == AUX_HALF - 1)
         o_aux <= ~o_aux;
   end
   // Line 0 ext, 1 burst key, 2 sync key, 3 gate key
   task drv(input int k, input logic v);
      @(posedge i_clk_sys);
      case (k)
         0: o_ext <= v;
         1: o_bkey <= v;
         2: o_sync <= v;
         default: o_gkey <= v;
      endcase
   endtask
   // Pulse 10 cycles wide, one per 51 cycles
   task pulse(input int k);
      drv(k, 1'b1);
      repeat (9) @(posedge i_clk_sys);
      drv(k, 1'b0);
      repeat (40) @(posedge i_clk_sys);
   endtask
endmodule
`default_nettype wire

// ### tb/burst_and_gate_controller_tb.sv
// Self-checking bench for the burst and gate controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module burst_and_gate_controller_tb;
   import bg_pkg::*;
   localparam int AUX = 40;
   logic              i_clk_sys = 1'b0;
   logic              i_rst = 1'b1;
   logic [ADDR_W-1:0] adr = '0;
   logic              rd_q = 1'b0;
   logic              wr_q = 1'b0;
   logic [31:0]       wd = '0;
   logic [3:0]        be = 4'hf;
   logic [31:0]       rdat;
   logic [31:0]       v;
   logic              wreq;
   logic              ext;
   logic              syn;
   logic              bk;
   logic              gk;
   logic              aux;
   logic              run;
   logic              tso;
   logic              act;
   logic              pae;
   int                hl;
   int                num_errors = 0;
   int                compares = 0;

   always #10 i_clk_sys = ~i_clk_sys;

   burst_and_gate_controller i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_avs_address(adr), .i_avs_read(rd_q), .i_avs_write(wr_q),
      .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
      .o_avs_waitrequest(wreq), .i_external_trigger_input(ext),
      .i_manual_sync_key(syn), .i_burst_mode_key(bk), .i_gate_key(gk),
      .i_aux_square(aux), .o_main_run(run), .o_trigger_sweep_output(tso),
      .o_burst_active(act), .o_phase_adjust_en(pae));

   burst_mode_key_far_model #(.AUX_HALF(AUX / 2)) i_far (.i_clk_sys(i_clk_sys), .o_ext(ext),
      .o_sync(syn), .o_bkey(bk), .o_gkey(gk), .o_aux(aux));

   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      adr <= a;
      wd <= d;
      wr_q <= 1'b1;
      do @(posedge i_clk_sys); while (wreq !== 1'b0);
      wr_q <= 1'b0;
   endtask
   task rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge i_clk_sys);
      adr <= a;
      rd_q <= 1'b1;
      do @(posedge i_clk_sys); while (wreq !== 1'b0);
      v = rdat;
      rd_q <= 1'b0;
      `CHK(v & m, e);
   endtask
   // Burst length in aux half cycles, rounded
   task burst(input int halves);
      int n;
      n = 0;
      repeat (4) @(posedge i_clk_sys);
      for (int i = 0; i < 300 && run !== 1'b1; i++) @(posedge i_clk_sys);
      `CHK(act, 1'b1);
      while (run === 1'b1 && n < 50000)
      begin
         @(posedge i_clk_sys);
         n++;
      end
      `CHK((n + AUX / 4) / (AUX / 2), halves);
   endtask
   task wtrig(input logic l);
      for (int i = 0; i < 30000 && tso !== l; i++) @(posedge i_clk_sys);
   endtask
   task hi_len();
      wtrig(1'b0);
      wtrig(1'b1);
      hl = 0;
      while (tso === 1'b1 && hl < 5000)
      begin
         @(posedge i_clk_sys);
         hl++;
      end
   endtask
   task test_done();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (90000) @(posedge i_clk_sys);
      num_errors++;
      test_done();
   end

   initial
   begin
      repeat (6) @(posedge i_clk_sys);
      i_rst <= 1'b0;
      `CHK({run, act, pae, wreq}, 4'hb);
      rchk(OFS_CTRL, '1, 32'h0);
      rchk(OFS_COUNT, '1, 32'h1);
      rchk(OFS_PERIOD, '1, 32'h3e8);
      rchk(OFS_KEYS, '1, 32'h0);
      rchk(5'h14, '1, 32'h0);
      // Byte lanes: only the low lane of the count is written
      be <= 4'h1;
      wr(OFS_COUNT, 32'h0000_02ff);
      be <= 4'hf;
      rchk(OFS_COUNT, '1, 32'h0ff);
      wr(OFS_PERIOD, 32'h14);
      rchk(OFS_STATUS, 32'h1f0, 32'h100);
      wr(OFS_CTRL, 32'h328);
      rchk(OFS_STATUS, 32'h1f0, 32'h0f0);
      wr(OFS_CTRL, 32'hc00);
      repeat (2) @(posedge i_clk_sys);
      `CHK(pae, 1'b0);
      wr(OFS_CTRL, 32'hc80);
      repeat (2) @(posedge i_clk_sys);
      `CHK(pae, 1'b1);
      wr(OFS_CTRL, 32'h0);
      // Mode keys toggle
      for (int k = 0; k < 4; k++)
      begin
         i_far.pulse(k < 2 ? 1 : 3);
         rchk(OFS_CTRL, 32'h3, (k % 2) ? 32'h0 : (k < 2 ? 32'h1 : 32'h2));
      end
      // External bursts, second edge inside the burst
      wr(OFS_COUNT, 32'h3);
      wr(OFS_CTRL, 32'h1);
      repeat (4) @(posedge i_clk_sys);
      `CHK(run, 1'b0);
      fork
         begin
            i_far.pulse(0);
            i_far.pulse(0);
         end
         burst(6);
      join
      repeat (100) @(posedge i_clk_sys);
      `CHK(act, 1'b0);
      // Manual key and remote command
      wr(OFS_CTRL, 32'h5);
      fork
         i_far.pulse(2);
         burst(6);
      join
      fork
         wr(OFS_KEYS, 32'h4);
         burst(6);
      join
      wr(OFS_CTRL, 32'h45);
      fork
         i_far.pulse(2);
         burst(3);
      join
      wr(OFS_COUNT, 32'h1);
      fork
         i_far.pulse(2);
         burst(1);
      join
      // Internal generator bursts
      wr(OFS_CTRL, 32'h9);
      repeat (2)
      begin
         wtrig(1'b0);
         wtrig(1'b1);
         burst(2);
      end
      hi_len();
      hi_len();
      `CHK((hl + 2) / 4, 125);
      wr(OFS_PERIOD, 32'h15);
      hi_len();
      hi_len();
      `CHK((hl + 2) / 4, 250);
      // Gating by generator, external level, manual toggle
      wr(OFS_CTRL, 32'h22);
      wtrig(1'b0);
      wtrig(1'b1);
      repeat (20) @(posedge i_clk_sys);
      `CHK(run, 1'b1);
      wtrig(1'b0);
      repeat (20) @(posedge i_clk_sys);
      `CHK(run, 1'b0);
      wr(OFS_CTRL, 32'h2);
      i_far.drv(0, 1'b1);
      repeat (10) @(posedge i_clk_sys);
      `CHK(run, 1'b1);
      i_far.drv(0, 1'b0);
      repeat (10) @(posedge i_clk_sys);
      `CHK(run, 1'b0);
      wr(OFS_CTRL, 32'h12);
      repeat (4) @(posedge i_clk_sys);
      for (int k = 0; k < 2; k++)
      begin
         v[0] = run;
         i_far.pulse(2);
         `CHK(run, ~v[0]);
         rchk(OFS_STATUS, 32'h204, v[0] ? 32'h0 : 32'h204);
      end
      test_done();
   end
endmodule
`default_nettype wire
